// ===== verilog/pwr_regs.svh
// Timing constants and reset values for the power button and wake controller.
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH

// ----------------------------------------------------------------------------
// Clock rate
// ----------------------------------------------------------------------------
`define CORE_CLK_HZ        20000000

// ----------------------------------------------------------------------------
// Press timing: times in milliseconds, counts derived from the clock rate
// ----------------------------------------------------------------------------
`define LONG_PRESS_MS      4000
`define LONG_PRESS_CYC     (`LONG_PRESS_MS * (`CORE_CLK_HZ / 1000))
`define DEBOUNCE_MS        10
`define DEBOUNCE_CYC       (`DEBOUNCE_MS * (`CORE_CLK_HZ / 1000))

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
// Video starts asleep: reset lands in soft off, so the first power-on is a wake too.
`define VIDEO_ASLEEP_RST   1'b1
`define SW_IDLE_RST        1'b1

`endif

// ===== verilog/pwr_pkg.sv
// Types shared by the power button and wake controller.
package pwr_pkg;

  // --------------------------------------------------------------------------
  // Global power state, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_S0 = 5'h01,  // Working.
    ST_S1 = 5'h02,  // Processor stopped.
    ST_S3 = 5'h04,  // Suspend to RAM.
    ST_S4 = 5'h08,  // Suspend to disk.
    ST_S5 = 5'h10   // Soft off.
  } pstate_type;

  // --------------------------------------------------------------------------
  // Press timer state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        sw_reg;      // Debounced switch level, low when pressed.
    logic [31:0] deb_reg;     // Stability counter for the debouncer.
    logic [31:0] hold_reg;    // Length of the current press.
    logic        long_reg;    // A long press was already reported.
    logic        short_reg;   // Short-press pulse.
    logic        lpulse_reg;  // Long-press pulse.
  } timer_type;

  // --------------------------------------------------------------------------
  // Controller state
  // --------------------------------------------------------------------------
  typedef struct packed {
    pstate_type  st_reg;      // Current global state.
    logic        video_reg;   // Video left asleep.
    logic        usb_reg;     // USB port power.
    logic        main_reg;    // Main supply enable.
    logic        wake_reg;    // One-cycle wake pulse.
  } ctrl_type;

endpackage

// ===== verilog/press_if.sv
// Carrier for press events between the press timer and the controller.
`timescale 1ns/10ps
`default_nettype none
interface press_if;
  logic short_press;  // One-cycle pulse: press released before the threshold.
  logic long_press;   // One-cycle pulse: press reached the threshold.

  modport timer (output short_press, output long_press);
  modport ctrl  (input short_press, input long_press);
endinterface
`default_nettype wire

// ===== verilog/press_timer.sv
// Debouncer and press-length classifier for the power switch.
`timescale 1ns/10ps
`default_nettype none
`include "pwr_regs.svh"
module press_timer
  import pwr_pkg::*;
#(
  parameter int unsigned LONG_CYC = `LONG_PRESS_CYC,
  parameter int unsigned DEB_CYC  = `DEBOUNCE_CYC
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Raw switch, low while pressed.
  input  wire logic sw_n,
  // Press events.
  press_if.timer    prs
);

  timer_type r_reg;   // All state.
  timer_type r_next;  // Next state.

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // The switch level only flips after it has been steady for DEB_CYC cycles,
  // so contact bounce never produces a second press.
  always_comb begin
    r_next = r_reg;
    r_next.short_reg  = 1'b0;
    r_next.lpulse_reg = 1'b0;
    if (sw_n == r_reg.sw_reg) begin
      r_next.deb_reg = 32'h0;
    end else if (r_reg.deb_reg >= DEB_CYC - 1) begin
      r_next.deb_reg = 32'h0;
      r_next.sw_reg  = sw_n;
    end else begin
      r_next.deb_reg = r_reg.deb_reg + 32'h1;
    end
    // Time the press; classify on release or at the threshold.
    if (!r_reg.sw_reg) begin
      if (r_reg.hold_reg < LONG_CYC) begin
        r_next.hold_reg = r_reg.hold_reg + 32'h1;
      end
      if (r_reg.hold_reg == LONG_CYC - 1 && !r_reg.long_reg) begin
        r_next.lpulse_reg = 1'b1;
        r_next.long_reg   = 1'b1;
      end
    end else begin
      r_next.hold_reg = 32'h0;
      r_next.long_reg = 1'b0;
    end
    // Release of a press that never reached the threshold.
    if (!r_reg.sw_reg && r_next.sw_reg && !r_reg.long_reg && !r_next.lpulse_reg) begin
      r_next.short_reg = 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '{sw_reg: `SW_IDLE_RST, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prs.short_press = r_reg.short_reg;
  assign prs.long_press  = r_reg.lpulse_reg;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_long_single: assert property (@(posedge clk) disable iff (rst)
    r_reg.lpulse_reg |=> !r_reg.lpulse_reg && !r_reg.short_reg [*2])
    else $error("long press reported twice or followed by short press");

endmodule
`default_nettype wire

// ===== verilog/power_button_wake_controller.sv
// Power-state controller: power switch, operating-system commands and wake sources.
// How it works
// - Short press: off to on, on to sleep, sleep to on
// - Long press while on or asleep forces soft off
// - Other transitions out of S0 only on operating-system command
// - Operating system can command soft off directly
// - Express wake line wakes only when enabled
// - LAN, PME, switch, RTC, PS/2 wake from any sleep
// - Serial and USB wake only from S1 or S3
// - USB power removed in S4 and S5
// - Video stays asleep after a wake
// - PME wake only when its enable is set
// - PS/2 in S5 wakes only on selected key
`timescale 1ns/10ps
`default_nettype none
`include "pwr_regs.svh"
module power_button_wake_controller
  import pwr_pkg::*;
#(
  parameter int unsigned LONG_PRESS_CYC = `LONG_PRESS_CYC,  // Long-press threshold.
  parameter int unsigned DEBOUNCE_CYC   = `DEBOUNCE_CYC     // Switch settling time.
) (
  // Clock and reset.
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Front panel switch, low while pressed.
  input  wire logic       PWR_SW_N,
  // Wake sources.
  input  wire logic       LAN_WAKE,
  input  wire logic       PME_N,
  input  wire logic       PCIE_WAKE_N,
  input  wire logic       RTC_ALARM,
  input  wire logic       SERIAL_ACT,
  input  wire logic       USB_ACT,
  input  wire logic       PS2_ACT,
  input  wire logic       PS2_ALT_PRTSCR,
  input  wire logic       PS2_POWER_KEY,
  // Wake and sleep configuration levels.
  input  wire logic       PCIE_WAKE_EN,
  input  wire logic       PME_WAKE_EN,
  input  wire logic       PS2_KEY_SEL,
  input  wire logic       BTN_SLEEP_DEEP,
  // Operating-system commands, one-cycle pulses.
  input  wire logic       OS_SLEEP_REQ,
  input  wire logic [4:0] OS_SLEEP_TGT,
  input  wire logic       OS_SOFT_OFF_REQ,
  input  wire logic       OS_VIDEO_ON,
  // Status and power controls.
  output logic      [4:0] PWR_STATE,
  output logic            MAIN_PWR_ON,
  output logic            USB_PWR_ON,
  output logic            VIDEO_ASLEEP,
  output logic            WAKE_PULSE
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // True in any sleeping state, S5 included.
  function automatic logic is_asleep(input pstate_type s);
    is_asleep = (s != ST_S0);
  endfunction

  // True in the deep states where USB and serial are powered down.
  function automatic logic is_deep(input pstate_type s);
    is_deep = (s == ST_S4) || (s == ST_S5);
  endfunction

  // ----------------------------------------------------------------------------
  // Press timer
  // ----------------------------------------------------------------------------
  press_if prs ();

  press_timer #(
    .LONG_CYC (LONG_PRESS_CYC),
    .DEB_CYC  (DEBOUNCE_CYC)
  ) u_timer (
    .clk  (CORE_CLK),
    .rst  (RST),
    .sw_n (PWR_SW_N),
    .prs  (prs.timer)
  );

  ctrl_type   c_reg;      // All controller state.
  ctrl_type   c_next;     // Next controller state.
  logic       wake_req;   // Some enabled source asks for wake.
  logic       ps2_wake;   // PS/2 activity that qualifies in this state.
  logic       tgt_ok;     // Operating-system target is a legal sleep state.
  pstate_type st_next;    // Next global state.

  // ----------------------------------------------------------------------------
  // Wake qualification
  // ----------------------------------------------------------------------------
  // Sources are masked by the states they may wake from or by their enable; LAN and RTC are never masked.
  always_comb begin
    if (c_reg.st_reg == ST_S5) begin
      ps2_wake = PS2_KEY_SEL ? PS2_POWER_KEY : PS2_ALT_PRTSCR;
    end else begin
      ps2_wake = PS2_ACT;
    end
    wake_req = LAN_WAKE || RTC_ALARM || ps2_wake
             || (!PME_N && PME_WAKE_EN)
             || (!PCIE_WAKE_N && PCIE_WAKE_EN)
             || (!is_deep(c_reg.st_reg) && (SERIAL_ACT || USB_ACT));
  end

  // ----------------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------------
  // Only the four sleeping states are accepted; any other code is ignored.
  always_comb begin
    case (OS_SLEEP_TGT)
      ST_S1, ST_S3, ST_S4, ST_S5: tgt_ok = 1'b1;
      default:                    tgt_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Global state machine
  // ----------------------------------------------------------------------------
  // In every state but S5 a long press wins over everything, so a hung operating system can always
  // be switched off from the front panel.
  always_comb begin
    st_next = c_reg.st_reg;
    case (c_reg.st_reg)
      ST_S0: begin
        if (prs.long_press) begin
          st_next = ST_S5;
        end else if (OS_SOFT_OFF_REQ) begin
          st_next = ST_S5;
        end else if (prs.short_press) begin
          st_next = BTN_SLEEP_DEEP ? ST_S3 : ST_S1;
        end else if (OS_SLEEP_REQ && tgt_ok) begin
          st_next = pstate_type'(OS_SLEEP_TGT);
        end
      end
      ST_S1, ST_S3, ST_S4: begin
        if (prs.long_press) begin
          st_next = ST_S5;
        end else if (prs.short_press || wake_req) begin
          st_next = ST_S0;
        end
      end
      ST_S5: begin
        if (prs.short_press || wake_req) begin
          st_next = ST_S0;
        end
      end
      default: st_next = ST_S5;
    endcase
  end

  // ----------------------------------------------------------------------------
  // Outputs as next state
  // ----------------------------------------------------------------------------
  // Outputs are derived from the next state so that they change in the same
  // edge as the state and come straight from flip-flops.
  always_comb begin
    c_next        = c_reg;
    c_next.st_reg = st_next;
    c_next.main_reg = (st_next == ST_S0) || (st_next == ST_S1);
    c_next.usb_reg  = !is_deep(st_next);
    c_next.wake_reg = is_asleep(c_reg.st_reg) && !is_asleep(st_next);
    if (!is_asleep(c_reg.st_reg) && is_asleep(st_next)) begin
      c_next.video_reg = 1'b1;
    end else if (OS_VIDEO_ON && (c_reg.st_reg == ST_S0)) begin
      c_next.video_reg = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // Reset lands in soft off: the standby domain must not power the board up
  // on its own.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      c_reg <= '{st_reg: ST_S5, video_reg: `VIDEO_ASLEEP_RST, default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign PWR_STATE    = c_reg.st_reg;
  assign MAIN_PWR_ON  = c_reg.main_reg;
  assign USB_PWR_ON   = c_reg.usb_reg;
  assign VIDEO_ASLEEP = c_reg.video_reg;
  assign WAKE_PULSE   = c_reg.wake_reg;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic others_idle;  // Only serial or USB could be asking for wake.
  assign others_idle = !LAN_WAKE && !RTC_ALARM && !PS2_ACT && !PS2_ALT_PRTSCR
                     && !PS2_POWER_KEY && PME_N && PCIE_WAKE_N;

  a_short_from_off: assert property (
    c_reg.st_reg == ST_S5 && prs.short_press |=> c_reg.st_reg == ST_S0 && WAKE_PULSE)
    else $error("short press did not power on");
  a_short_to_sleep: assert property (
    c_reg.st_reg == ST_S0 && prs.short_press && !OS_SOFT_OFF_REQ && !prs.long_press
    |=> c_reg.st_reg == ($past(BTN_SLEEP_DEEP) ? ST_S3 : ST_S1))
    else $error("short press did not enter sleep");
  a_long_forces_off: assert property (
    prs.long_press && c_reg.st_reg != ST_S5 |=> c_reg.st_reg == ST_S5 && !MAIN_PWR_ON)
    else $error("long press did not force soft off");
  a_os_only_change: assert property (
    c_reg.st_reg == ST_S0 && !prs.short_press && !prs.long_press && !OS_SOFT_OFF_REQ
    && !(OS_SLEEP_REQ && tgt_ok) |=> $stable(c_reg.st_reg))
    else $error("working state left without a command");
  a_soft_off_cmd: assert property (
    c_reg.st_reg == ST_S0 && OS_SOFT_OFF_REQ |=> c_reg.st_reg == ST_S5 && !WAKE_PULSE)
    else $error("soft-off command not obeyed");
  a_pcie_gated: assert property (
    c_reg.st_reg == ST_S5 && !PCIE_WAKE_N && !PCIE_WAKE_EN && !LAN_WAKE && !RTC_ALARM
    && PME_N && !PS2_ALT_PRTSCR && !PS2_POWER_KEY && !prs.short_press
    |=> c_reg.st_reg == ST_S5)
    else $error("disabled express wake woke the system");
  a_lan_wakes: assert property (
    is_asleep(c_reg.st_reg) && LAN_WAKE && !prs.long_press |=> c_reg.st_reg == ST_S0)
    else $error("LAN wake ignored");
  a_serial_deep: assert property (
    is_deep(c_reg.st_reg) && others_idle && !prs.short_press && !prs.long_press
    |=> $stable(c_reg.st_reg))
    else $error("serial or USB woke a deep state");
  a_usb_power: assert property (
    is_deep(c_reg.st_reg) |-> !USB_PWR_ON)
    else $error("USB powered in a deep state");
  a_video_stays: assert property (
    $rose(WAKE_PULSE) |-> VIDEO_ASLEEP)
    else $error("video woke with the system");
  a_pme_gated: assert property (
    c_reg.st_reg == ST_S4 && !PME_N && !PME_WAKE_EN && LAN_WAKE == 1'b0 && !RTC_ALARM
    && !PS2_ACT && PCIE_WAKE_N && !prs.short_press && !prs.long_press
    |=> c_reg.st_reg == ST_S4)
    else $error("disabled PME woke the system");
  a_ps2_key_s5: assert property (
    c_reg.st_reg == ST_S5 && PS2_KEY_SEL && PS2_POWER_KEY |=> c_reg.st_reg == ST_S0)
    else $error("power key did not wake from soft off");

  c_wake_s3:   cover property (c_reg.st_reg == ST_S3 ##1 c_reg.st_reg == ST_S0);
  c_long_off:  cover property (c_reg.st_reg == ST_S0 && prs.long_press);
  c_os_s4:     cover property (c_reg.st_reg == ST_S0 ##1 c_reg.st_reg == ST_S4);

endmodule
`default_nettype wire

// ===== verification/pwr_partner.sv
// Model of the front panel switch and the wake-capable peripherals.
`timescale 1ns/10ps
`default_nettype none
module pwr_partner (
  // Clock.
  input  wire logic clk,
  // Switch and wake lines, at idle levels when quiet.
  output var logic  sw_n,
  output var logic  lan,
  output var logic  pme_n,
  output var logic  pcie_n,
  output var logic  rtc,
  output var logic  ser,
  output var logic  usb,
  output var logic  ps2,
  output var logic  chord,
  output var logic  pkey
);
  // ----------------------------------------
  // Idle levels and stimulus tasks
  // ----------------------------------------
  // Active-low lines idle high, the rest idle low.
  initial begin
    {lan, rtc, ser, usb, ps2, chord, pkey} = 7'h00;
    {sw_n, pme_n, pcie_n} = 3'h7;
  end

  // Holds the switch down n cycles; a real switch bounces, the debouncer hides that.
  task automatic press(input int n);
    @(posedge clk);
    sw_n <= 1'b0;
    repeat (n) @(posedge clk);
    sw_n <= 1'b1;
  endtask

  // Raises one wake source for two cycles, then drops it again.
  task automatic wake(input int src);
    @(posedge clk);
    drive(src, 1'b1);
    repeat (2) @(posedge clk);
    drive(src, 1'b0);
  endtask

  // Key chords always come with plain activity, as a keyboard sends them.
  task automatic drive(input int src, input logic on);
    case (src)
      0: lan <= on;
      1: pme_n <= !on;
      2: pcie_n <= !on;
      3: rtc <= on;
      4: ser <= on;
      5: usb <= on;
      6: ps2 <= on;
      7: {ps2, chord} <= {on, on};
      default: {ps2, pkey} <= {on, on};
    endcase
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_power_button_wake_controller.sv
// Self-checking bench for the power button and wake controller.
`timescale 1ns/10ps
`default_nettype none
module tb_power_button_wake_controller
  import pwr_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       core_clk   = 1'b0;   // Core clock.
  logic       rst        = 1'b1;   // Synchronous reset.
  logic       pcie_en    = 1'b1;   // Express wake enable.
  logic       pme_en     = 1'b1;   // PME wake enable.
  logic       key_sel    = 1'b0;   // S5 key choice.
  logic       deep       = 1'b0;   // Short press sleeps to S3 when set.
  logic       slp_req    = 1'b0;   // Sleep command.
  logic [4:0] slp_tgt    = 5'h00;  // Sleep target.
  logic       off_req    = 1'b0;   // Soft-off command.
  logic       vid_on     = 1'b0;   // Video wake command.
  wire  logic sw_n, lan, pme_n, pcie_n, rtc, ser, usb, ps2, chord, pkey;
  logic [4:0] pwr_state;           // Observed state.
  logic       main_on, usb_on, vid_slp, wake_p;
  int         n_mismatch = 0;      // Mismatches seen.
  int         checks     = 0;      // Comparisons made.
  int         pulses     = 0;      // Wake pulses counted.

  // Short counts keep the run brief; expectations use the same figures.
  power_button_wake_controller #(.LONG_PRESS_CYC(40), .DEBOUNCE_CYC(3))
  u_power_button_wake_controller (
    .CORE_CLK(core_clk), .RST(rst), .PWR_SW_N(sw_n), .LAN_WAKE(lan),
    .PME_N(pme_n), .PCIE_WAKE_N(pcie_n), .RTC_ALARM(rtc), .SERIAL_ACT(ser),
    .USB_ACT(usb), .PS2_ACT(ps2), .PS2_ALT_PRTSCR(chord), .PS2_POWER_KEY(pkey),
    .PCIE_WAKE_EN(pcie_en), .PME_WAKE_EN(pme_en), .PS2_KEY_SEL(key_sel),
    .BTN_SLEEP_DEEP(deep), .OS_SLEEP_REQ(slp_req), .OS_SLEEP_TGT(slp_tgt),
    .OS_SOFT_OFF_REQ(off_req), .OS_VIDEO_ON(vid_on), .PWR_STATE(pwr_state),
    .MAIN_PWR_ON(main_on), .USB_PWR_ON(usb_on), .VIDEO_ASLEEP(vid_slp),
    .WAKE_PULSE(wake_p));

  pwr_partner u_pwr_partner (
    .clk(core_clk), .sw_n(sw_n), .lan(lan), .pme_n(pme_n), .pcie_n(pcie_n),
    .rtc(rtc), .ser(ser), .usb(usb), .ps2(ps2), .chord(chord), .pkey(pkey));

  // ----------------------------------------
  // Clock, pulse counter and helpers
  // ----------------------------------------
  // Half period of 25 ns gives 20 MHz.
  always #25 core_clk = ~core_clk;

  // Counting pulses lets a late or doubled pulse show up.
  always @(posedge core_clk) begin
    if (wake_p === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // Compares with case equality so an unknown never matches.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // Waits n edges and samples once their updates have landed.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Presses the switch and waits, bounded, for the state that must follow.
  task automatic press_to(input int n, input logic [4:0] st);
    int i;
    u_pwr_partner.press(n);
    for (i = 0; i < 200 && pwr_state !== st; i++) begin
      tick(1);
    end
    if (pwr_state !== st) begin
      check("state wait", pwr_state, st);
      summarize();
    end
    tick(10);
    check("press state", pwr_state, st);
  endtask

  // Kind 0 sleeps to tgt, 1 powers off, 2 wakes video.
  task automatic os_cmd(input int kind, input logic [4:0] tgt);
    @(posedge core_clk);
    slp_tgt <= tgt;
    slp_req <= (kind == 0);
    off_req <= (kind == 1);
    vid_on  <= (kind == 2);
    @(posedge core_clk);
    {slp_req, off_req, vid_on} <= 3'h0;
    #1;
  endtask

  // Which sources may wake which states, under the current settings.
  function automatic logic exp_wake(input logic [4:0] st, input int src);
    case (src)
      1: return pme_en;
      2: return pcie_en;
      4, 5: return st == ST_S1 || st == ST_S3;
      6: return st != ST_S5;
      7: return st != ST_S5 || !key_sel;
      8: return st != ST_S5 || key_sel;
      default: return 1'b1;
    endcase
  endfunction

  // Brings the system to S0 with video awake, then commands state st.
  task automatic go_sleep(input logic [4:0] st);
    if (pwr_state !== ST_S0) begin
      press_to(15, ST_S0);
    end
    os_cmd(2, 5'h00);
    check("video", vid_slp, 1'b0);
    os_cmd(st == ST_S5, st);
    check("state", pwr_state, st);
    check("usb", usb_on, st == ST_S1 || st == ST_S3);
  endtask

  // One wake source fired in one state.
  task automatic trial(input logic [4:0] st, input int src);
    int   p0;
    logic w;
    w = exp_wake(st, src);
    go_sleep(st);
    p0 = pulses;
    u_pwr_partner.wake(src);
    tick(5);
    check("wake", pwr_state, w ? ST_S0 : st);
    check("main", main_on, w || st == ST_S1);
    if (w) begin
      check("pulses", pulses - p0, 1);
      check("video", vid_slp, 1'b1);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Short presses cycle the states; long presses force soft off.
  task automatic t_button();
    press_to(15, ST_S0);
    press_to(30, ST_S1);
    press_to(15, ST_S0);
    @(posedge core_clk);
    deep <= 1'b1;
    press_to(15, ST_S3);
    press_to(60, ST_S5);
    press_to(60, ST_S5);
    press_to(15, ST_S0);
    press_to(60, ST_S5);
  endtask

  // Bad targets and commands outside S0 must change nothing.
  task automatic t_os();
    press_to(15, ST_S0);
    os_cmd(0, ST_S0);
    check("bad target", pwr_state, ST_S0);
    os_cmd(0, 5'h06);
    check("two targets", pwr_state, ST_S0);
    os_cmd(0, ST_S4);
    check("to S4", pwr_state, ST_S4);
    check("usb in S4", usb_on, 1'b0);
    check("main in S4", main_on, 1'b0);
    os_cmd(1, 5'h00);
    check("off asleep", pwr_state, ST_S4);
    os_cmd(0, ST_S1);
    check("sleep asleep", pwr_state, ST_S4);
    press_to(15, ST_S0);
    os_cmd(1, 5'h00);
    check("soft off", pwr_state, ST_S5);
    check("usb in S5", usb_on, 1'b0);
  endtask

  // Every source from every sleep state, then the enables and key choice.
  task automatic t_wakes();
    logic [4:0] sts [4];
    int         i;
    int         s;
    sts = '{ST_S1, ST_S3, ST_S4, ST_S5};
    for (i = 0; i < 4; i++) begin
      for (s = 0; s < 9; s++) begin
        trial(sts[i], s);
      end
    end
    @(posedge core_clk);
    {pme_en, pcie_en} <= 2'b00;
    tick(1);
    trial(ST_S3, 1);
    trial(ST_S4, 1);
    trial(ST_S5, 2);
    @(posedge core_clk);
    key_sel <= 1'b1;
    tick(1);
    trial(ST_S5, 7);
    trial(ST_S5, 8);
  endtask

  // The single place where the run ends.
  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    check("reset state", pwr_state, ST_S5);
    check("reset usb", usb_on, 1'b0);
    check("reset main", main_on, 1'b0);
    check("reset pulse", wake_p, 1'b0);
    check("reset video", vid_slp, 1'b1);
    t_button();
    t_os();
    t_wakes();
    summarize();
  end
endmodule
`default_nettype wire
